// File: design/magnet_lost_pkg.sv
// package: register map, field layout and types for the magnet-loss monitor
package magnet_lost_pkg;

	// register map (16-bit word addresses)
	localparam logic [15:0] LIMIT_CONFIG_ADDR = 16'h000F;
	localparam logic [15:0] STATUS_ADDR       = 16'h0107;
	localparam logic [15:0] MAGNITUDE_ADDR    = 16'h0121;
	localparam logic [15:0] IRQ_STATUS_ADDR   = 16'h0140;
	localparam logic [15:0] IRQ_MASK_ADDR     = 16'h0141;

	// configuration field layout
	localparam int THRESH_LSB = 0;
	localparam int THRESH_MSB = 7;
	localparam int HYST_LSB   = 8;
	localparam int HYST_MSB   = 10;
	localparam logic [15:0] LIMIT_CONFIG_RESET = 16'h0103;
	localparam logic [15:0] LIMIT_CONFIG_WMASK = 16'h07FF;

	// threshold scale is 64, i.e. a left shift by six
	localparam int THRESH_SCALE_SHIFT = 6;

	// status register: magnet-absent flag position
	localparam int ABSENT_BIT = 0;

	// interrupt event bits
	localparam int EVT_LOST_BIT   = 0;
	localparam int EVT_FOUND_BIT  = 1;
	localparam int EVT_WIDTH      = 2;
	localparam logic [EVT_WIDTH-1:0] IRQ_MASK_RESET = 2'h0;

	// reset values of the remaining state registers
	localparam logic [15:0]          MAGNITUDE_RESET  = 16'h0000;
	localparam logic                 ABSENT_RESET     = 1'b0;
	localparam logic [EVT_WIDTH-1:0] IRQ_STATUS_RESET = 2'h0;
	localparam logic [15:0]          RDATA_RESET      = 16'h0000;

	// decoded configuration
	typedef struct packed {
		logic [2:0] hystShift;
		logic [7:0] lossThreshold;
	} limit_cfg_t;

	// register port request
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_t;

endpackage : magnet_lost_pkg

// File: design/magnet_lost_monitor.sv
// magnet-loss monitor: threshold and hysteresis compare on the cordic magnitude
`timescale 1ns/1ps

// Notes on behaviour
// - minimum magnitude threshold is the 8-bit threshold field times 64
// - threshold is compared against the cordic magnitude result register
// - magnitude below threshold sets the magnet-absent flag from 0 to 1
// - hysteresis equals threshold right-shifted by the 3-bit hysteresis field
// - a set flag clears only when magnitude exceeds threshold plus hysteresis
// - config bits 10:8 hysteresis, 7:0 threshold, 15:11 read zero
module magnet_lost_monitor
	import magnet_lost_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [15:0] magnitude,
	input  wire logic        magnitudeValid,
	input  wire logic [15:0] regAddr,
	input  wire logic [15:0] regWdata,
	input  wire logic        regWr,
	input  wire logic        regRd,
	output logic      [15:0] regRdata,
	output logic             magnetAbsentFlag,
	output logic             irq
);

	// register port bundle and decoded configuration
	reg_req_t   req;
	limit_cfg_t cfg;

	// configuration, mask and sticky status registers
	logic [15:0]          limitCfg_r;
	logic [15:0]          limitCfg_nxt;
	logic [EVT_WIDTH-1:0] irqMask_r;
	logic [EVT_WIDTH-1:0] irqMask_nxt;
	logic [EVT_WIDTH-1:0] irqStatus_r;
	logic [EVT_WIDTH-1:0] irqStatus_nxt;

	// sample and flag registers
	logic [15:0]          magnitude_r;
	logic [15:0]          magnitude_nxt;
	logic                 absent_r;
	logic                 absent_nxt;

	// read data register
	logic [15:0]          rdata_r;
	logic [15:0]          rdata_nxt;

	// per-register strobes from the address decoder
	logic                 wrConfig;
	logic                 wrMask;
	logic                 wrStatus;
	logic                 rdConfig;
	logic                 rdStatus;
	logic                 rdMagnitude;
	logic                 rdIrqStatus;
	logic                 rdIrqMask;

	// limit arithmetic, one bit wider than the magnitude so the sum cannot wrap
	logic [16:0]          lowerLimit;
	logic [16:0]          hystAmount;
	logic [16:0]          upperLimit;
	logic                 belowLimit;
	logic                 aboveUpper;
	logic                 lossEvent;
	logic                 foundEvent;

	// interrupt event, clear and pending bits
	logic [EVT_WIDTH-1:0] events;
	logic [EVT_WIDTH-1:0] evtClear;
	logic [EVT_WIDTH-1:0] evtPending;

	// bundle the register port and split the configuration into its fields
	assign req = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};
	assign cfg = limitCfg_r[HYST_MSB:THRESH_LSB];

	// address decoder: one strobe per register, unmapped addresses hit none
	always_comb
	begin
		wrConfig    = 1'b0;
		wrMask      = 1'b0;
		wrStatus    = 1'b0;
		rdConfig    = 1'b0;
		rdStatus    = 1'b0;
		rdMagnitude = 1'b0;
		rdIrqStatus = 1'b0;
		rdIrqMask   = 1'b0;
		if (req.addr == LIMIT_CONFIG_ADDR)
		begin
			wrConfig = req.wr;
			rdConfig = req.rd;
		end
		else if (req.addr == STATUS_ADDR)
		begin
			rdStatus = req.rd; // read-only: writes are dropped
		end
		else if (req.addr == MAGNITUDE_ADDR)
		begin
			rdMagnitude = req.rd; // read-only: writes are dropped
		end
		else if (req.addr == IRQ_STATUS_ADDR)
		begin
			wrStatus    = req.wr;
			rdIrqStatus = req.rd;
		end
		else if (req.addr == IRQ_MASK_ADDR)
		begin
			wrMask    = req.wr;
			rdIrqMask = req.rd;
		end
	end

	// threshold and hysteresis arithmetic on the live configuration
	always_comb
	begin
		lowerLimit = 17'(cfg.lossThreshold) << THRESH_SCALE_SHIFT;
		hystAmount = lowerLimit >> cfg.hystShift;
		upperLimit = lowerLimit + hystAmount;
		belowLimit = {1'b0, magnitude} < lowerLimit;
		aboveUpper = {1'b0, magnitude} > upperLimit;
	end

	// crossings only count on a new sample; both compares are strict
	always_comb
	begin
		lossEvent  = magnitudeValid && !absent_r && belowLimit;
		foundEvent = magnitudeValid && absent_r && aboveUpper;
	end

	// magnitude capture: the last valid sample is kept for read-back
	always_comb
	begin
		magnitude_nxt = magnitude_r;
		if (magnitudeValid)
		begin
			magnitude_nxt = magnitude;
		end
	end

	// magnitude register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			magnitude_r <= MAGNITUDE_RESET;
		end
		else
		begin
			magnitude_r <= magnitude_nxt;
		end
	end

	// flag update: set on a loss crossing, cleared on a recovery crossing
	always_comb
	begin
		absent_nxt = absent_r;
		if (lossEvent)
		begin
			absent_nxt = 1'b1;
		end
		else if (foundEvent)
		begin
			absent_nxt = 1'b0;
		end
		// no sample, or a sample inside the band: flag held
	end

	// flag register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			absent_r <= ABSENT_RESET;
		end
		else
		begin
			absent_r <= absent_nxt;
		end
	end

	// event strobes for the sticky interrupt status
	always_comb
	begin
		events                = '0;
		events[EVT_LOST_BIT]  = lossEvent;
		events[EVT_FOUND_BIT] = foundEvent;
	end

	// configuration write; reserved bits 15:11 are dropped
	always_comb
	begin
		limitCfg_nxt = limitCfg_r;
		if (wrConfig)
		begin
			limitCfg_nxt = req.wdata & LIMIT_CONFIG_WMASK;
		end
	end

	// configuration register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			limitCfg_r <= LIMIT_CONFIG_RESET;
		end
		else
		begin
			limitCfg_r <= limitCfg_nxt;
		end
	end

	// interrupt mask write
	always_comb
	begin
		irqMask_nxt = irqMask_r;
		if (wrMask)
		begin
			irqMask_nxt = req.wdata[EVT_WIDTH-1:0];
		end
	end

	// interrupt mask register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			irqMask_r <= IRQ_MASK_RESET;
		end
		else
		begin
			irqMask_r <= irqMask_nxt;
		end
	end

	// per-bit clear requests and pending interrupts
	generate
		for (genvar i = 0; i < EVT_WIDTH; i++)
		begin : g_evt
			assign evtClear[i]   = wrStatus && req.wdata[i];
			assign evtPending[i] = irqStatus_r[i] && irqMask_r[i];
		end
	endgenerate

	// sticky status: write one to clear, a new event in the same cycle wins
	always_comb
	begin
		irqStatus_nxt = (irqStatus_r & ~evtClear) | events;
	end

	// sticky status register
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			irqStatus_r <= IRQ_STATUS_RESET;
		end
		else
		begin
			irqStatus_r <= irqStatus_nxt;
		end
	end

	// read data, valid in the cycle after the read strobe; unmapped reads zero
	always_comb
	begin
		rdata_nxt = RDATA_RESET;
		if (rdConfig)
		begin
			rdata_nxt[HYST_MSB:HYST_LSB]     = cfg.hystShift;
			rdata_nxt[THRESH_MSB:THRESH_LSB] = cfg.lossThreshold;
		end
		else if (rdStatus)
		begin
			rdata_nxt[ABSENT_BIT] = absent_r;
		end
		else if (rdMagnitude)
		begin
			rdata_nxt = magnitude_r;
		end
		else if (rdIrqStatus)
		begin
			rdata_nxt[EVT_WIDTH-1:0] = irqStatus_r;
		end
		else if (rdIrqMask)
		begin
			rdata_nxt[EVT_WIDTH-1:0] = irqMask_r;
		end
	end

	// read data register; it drops back to zero one cycle after the read strobe ends
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rdata_r <= RDATA_RESET;
		end
		else
		begin
			rdata_r <= rdata_nxt;
		end
	end

	// flag and read data straight from the registers; the interrupt is a level, the OR of the masked status bits
	assign regRdata         = rdata_r;
	assign magnetAbsentFlag = absent_r;
	assign irq              = |evtPending;

endmodule : magnet_lost_monitor

// File: tb/magnet_lost_sva.sv
// checker: flag hysteresis and read-back properties at the monitor ports
`timescale 1ns/1ps
module magnet_lost_sva
	import magnet_lost_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [15:0] magnitude,
	input wire logic        magnitudeValid,
	input wire logic [15:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic        regWr,
	input wire logic        regRd,
	input wire logic [15:0] regRdata,
	input wire logic        magnetAbsentFlag,
	input wire logic        irq
);
	logic [10:0] cfg_r;
	wire logic [15:0] lossLimit = {2'h0, cfg_r[7:0], 6'h00};
	wire logic [15:0] clearLimit = lossLimit + (lossLimit >> cfg_r[10:8]);
	// shadow of the limit configuration
	always_ff @(posedge clk)
		if (rst) cfg_r <= 11'h103;
		else if (regWr && regAddr == LIMIT_CONFIG_ADDR) cfg_r <= regWdata[10:0];
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	a_flag_sets: assert property (magnitudeValid && magnitude < lossLimit |=> magnetAbsentFlag)
		else $error("flag not set below limit");
	a_flag_clears: assert property (magnitudeValid && magnitude > clearLimit |=> !magnetAbsentFlag)
		else $error("flag not cleared above band");
	a_band_holds: assert property (magnitudeValid && magnitude >= lossLimit
		&& magnitude <= clearLimit |=> $stable(magnetAbsentFlag))
		else $error("flag moved inside band");
	a_idle_holds: assert property (!magnitudeValid |=> $stable(magnetAbsentFlag))
		else $error("flag moved without sample");
	a_config_reads: assert property (regRd && regAddr == LIMIT_CONFIG_ADDR
		|=> regRdata == {5'h00, cfg_r})
		else $error("config read-back wrong");
	a_status_reads: assert property (regRd && regAddr == STATUS_ADDR
		|=> regRdata == {15'h0000, $past(magnetAbsentFlag)})
		else $error("status read-back wrong");
	a_rdata_idle: assert property (!regRd |=> regRdata == 16'h0000)
		else $error("read data not idle");
	cover property (magnitudeValid && magnitude < lossLimit);
	cover property ($fell(magnetAbsentFlag));
	cover property (regRd && regAddr == STATUS_ADDR);
endmodule : magnet_lost_sva
bind magnet_lost_monitor magnet_lost_sva u_sva (.*);

// File: tb/tb_magnet_lost_monitor.sv
// testbench: register access and flag hysteresis sequences
`timescale 1ns/1ps
module tb_magnet_lost_monitor;
	import magnet_lost_pkg::*;
	logic clk = 0, rst = 1, magnitudeValid = 0, regWr = 0, regRd = 0;
	logic [15:0] magnitude = 0, regAddr = 0, regWdata = 0, regRdata;
	logic magnetAbsentFlag, irq;
	int bad_count = 0, checks = 0;
	magnet_lost_monitor u_dut (
		.clk              (clk),
		.rst              (rst),
		.magnitude        (magnitude),
		.magnitudeValid   (magnitudeValid),
		.regAddr          (regAddr),
		.regWdata         (regWdata),
		.regWr            (regWr),
		.regRd            (regRd),
		.regRdata         (regRdata),
		.magnetAbsentFlag (magnetAbsentFlag),
		.irq              (irq)
	);
	initial forever #25 clk = ~clk;
	task chk(string n, logic [15:0] e, logic [15:0] g);
		checks++;
		if (e !== g)
		begin
			bad_count++;
			$display("mismatch %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task wr(logic [15:0] a, logic [15:0] d);
		@(posedge clk);
		regWr <= 1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWr <= 0;
		#1;
	endtask : wr
	task rd(logic [15:0] a, logic [15:0] e);
		@(posedge clk);
		regRd <= 1;
		regAddr <= a;
		@(posedge clk);
		regRd <= 0;
		#1 chk("rdata", e, regRdata);
	endtask : rd
	// one sample, flag checked one cycle later
	task mag(logic [15:0] v, logic e);
		@(posedge clk);
		magnitudeValid <= 1;
		magnitude <= v;
		@(posedge clk);
		magnitudeValid <= 0;
		#1 chk("flag", {15'h0000, e}, {15'h0000, magnetAbsentFlag});
	endtask : mag
	task conclude;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : conclude
	initial
	begin
		repeat (12) @(posedge clk);
		rst <= 0;
		rd(LIMIT_CONFIG_ADDR, 16'h0103);
		mag(16'h00BF, 1);
		rd(STATUS_ADDR, 16'h0001);
		rd(MAGNITUDE_ADDR, 16'h00BF);
		mag(16'h0120, 1);
		mag(16'h0121, 0);
		mag(16'h00C0, 0);
		rd(IRQ_STATUS_ADDR, 16'h0003);
		chk("irq", 16'h0000, {15'h0000, irq});
		wr(IRQ_MASK_ADDR, 16'h0001);
		chk("irq", 16'h0001, {15'h0000, irq});
		wr(IRQ_STATUS_ADDR, 16'h0003);
		chk("irq", 16'h0000, {15'h0000, irq});
		rd(16'h0055, 16'h0000);
		$display("test default limits done");
		wr(LIMIT_CONFIG_ADDR, 16'hFFFF);
		rd(LIMIT_CONFIG_ADDR, 16'h07FF);
		wr(LIMIT_CONFIG_ADDR, 16'h0204);
		chk("flag", 16'h0000, {15'h0000, magnetAbsentFlag});
		mag(16'h00FF, 1);
		mag(16'h0140, 1);
		mag(16'h0141, 0);
		$display("test new limits done");
		conclude();
	end
endmodule : tb_magnet_lost_monitor
